// >>> design/sxe_exec.sv
// Subroutine-exit instruction execution logic
`timescale 1ns/1ps
`default_nettype none
module sxe_exec
  import sxe_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Decoder side
  input wire logic [sxe_pkg::OPC_W-1:0] opcode_i,
  input wire logic opcode_valid_i,
  // Call stack
  input wire logic [sxe_pkg::PC_W-1:0] stack_top_i,
  output logic stack_pop_o,
  // Shadow register set
  input wire logic [sxe_pkg::DATA_W-1:0] accumulator_shadow_i,
  input wire logic [sxe_pkg::DATA_W-1:0] flags_shadow_i,
  input wire logic [sxe_pkg::DATA_W-1:0] bank_select_shadow_i,
  // Core register loads from other instructions
  input wire logic wreg_load_i,
  input wire logic [sxe_pkg::DATA_W-1:0] wreg_data_i,
  input wire logic flags_load_i,
  input wire logic [sxe_pkg::DATA_W-1:0] flags_data_i,
  input wire logic bank_load_i,
  input wire logic [sxe_pkg::DATA_W-1:0] bank_data_i,
  input wire logic latch_load_i,
  input wire logic [sxe_pkg::DATA_W-1:0] latch_upper_data_i,
  input wire logic [sxe_pkg::DATA_W-1:0] latch_high_data_i,
  // Architectural state
  output logic [sxe_pkg::PC_W-1:0] pc_o,
  output logic [sxe_pkg::DATA_W-1:0] wreg_o,
  output logic [sxe_pkg::DATA_W-1:0] flags_o,
  output logic [sxe_pkg::DATA_W-1:0] bank_select_reg_o,
  output logic [sxe_pkg::DATA_W-1:0] pc_latch_upper_o,
  output logic [sxe_pkg::DATA_W-1:0] pc_latch_high_o,
  // Status
  output logic busy_o
);
  import sxe_pkg::*;

  // ----------------------------------------
  // Phase and decode
  // ----------------------------------------
  logic [1:0] phase;
  sxe_state_t state_q;
  logic restore_q;
  logic is_exit;
  logic pop_now;
  logic restore_now;

  sxe_phase_gen u_phase (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .phase_o(phase)
  );

  // Decode only the single-word exit pattern
  assign is_exit = opcode_valid_i && ((opcode_i & OPC_EXIT_MASK) == OPC_EXIT_MATCH);
  assign pop_now = (state_q == SXE_POP) && (phase == PHASE_Q4);
  assign restore_now = pop_now && restore_q;

  // ----------------------------------------
  // Two-cycle sequence
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= SXE_IDLE;
      restore_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        SXE_IDLE:
        begin
          if (is_exit && phase == PHASE_Q1)
          begin
            state_q <= SXE_POP;
            restore_q <= opcode_i[OPC_RESTORE_BIT];
          end
        end
        SXE_POP:
        begin
          if (phase == PHASE_Q4)
            state_q <= SXE_NOP;
        end
        SXE_NOP:
        begin
          if (phase == PHASE_Q4)
            state_q <= SXE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state_q != SXE_IDLE) && !(state_q == SXE_NOP && phase == PHASE_Q4);
  end

  // ----------------------------------------
  // Stack pop and program counter
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stack_pop_o <= 1'b0;
      pc_o <= PC_RESET;
    end
    else
    begin
      stack_pop_o <= pop_now;
      if (pop_now)
        pc_o <= stack_top_i;
    end
  end

  // ----------------------------------------
  // Working, flags and bank registers
  // ----------------------------------------
  // Restore has priority over a same-cycle load; the exit owns the core then
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wreg_o <= REG_RESET;
      flags_o <= REG_RESET;
      bank_select_reg_o <= REG_RESET;
    end
    else if (restore_now)
    begin
      wreg_o <= accumulator_shadow_i;
      flags_o <= flags_shadow_i;
      bank_select_reg_o <= bank_select_shadow_i;
    end
    else if (state_q == SXE_IDLE)
    begin
      // Outside the exit only, so a clear restore bit leaves all three as they were
      if (wreg_load_i)
        wreg_o <= wreg_data_i;
      if (flags_load_i)
        flags_o <= flags_data_i;
      if (bank_load_i)
        bank_select_reg_o <= bank_data_i;
    end
  end

  // ----------------------------------------
  // Program counter latches
  // ----------------------------------------
  // The pop never writes these; only other instructions do
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pc_latch_upper_o <= REG_RESET;
      pc_latch_high_o <= REG_RESET;
    end
    else if (latch_load_i && state_q == SXE_IDLE)
    begin
      pc_latch_upper_o <= latch_upper_data_i;
      pc_latch_high_o <= latch_high_data_i;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence exit_start_s;
    state_q == SXE_IDLE && is_exit && phase == PHASE_Q1;
  endsequence

  pop_timing_a: assert property (@(posedge clk_i) disable iff (reset_i)
    exit_start_s |-> ##4 stack_pop_o)
    else $error("pop not at fourth phase of first cycle");

  pc_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
    pop_now |=> pc_o == $past(stack_top_i))
    else $error("pc not loaded from stack top");

  restore_set_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (pop_now && restore_q) |=> wreg_o == $past(accumulator_shadow_i)
      && flags_o == $past(flags_shadow_i) && bank_select_reg_o == $past(bank_select_shadow_i))
    else $error("shadow restore missing");

  restore_clr_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q != SXE_IDLE && !restore_now) |=> $stable(wreg_o) && $stable(flags_o)
      && $stable(bank_select_reg_o))
    else $error("registers changed without restore");

  latch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    state_q != SXE_IDLE |=> $stable(pc_latch_upper_o) && $stable(pc_latch_high_o))
    else $error("pc latches changed during exit");

  two_cycle_a: assert property (@(posedge clk_i) disable iff (reset_i)
    exit_start_s |=> (state_q != SXE_IDLE) [*7] ##1 state_q == SXE_IDLE)
    else $error("exit not two instruction cycles");

  single_pop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    stack_pop_o |=> !stack_pop_o [*7])
    else $error("more than one pop per exit");

  pc_only_pop_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(pop_now) |-> $stable(pc_o))
    else $error("pc changed without pop");

  // Last phase of the second, empty cycle
  sequence exit_end_s;
    state_q == SXE_NOP && phase == PHASE_Q4;
  endsequence

  // Busy is registered, so it trails the take by one edge
  busy_span_a: assert property (@(posedge clk_i) disable iff (reset_i)
    exit_start_s |=> ##1 busy_o [*6] ##1 !busy_o)
    else $error("busy not held across both cycles");

  off_phase_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_q == SXE_IDLE && phase != PHASE_Q1) |=> state_q == SXE_IDLE)
    else $error("exit taken outside first phase");

  exit_end_a: assert property (@(posedge clk_i) disable iff (reset_i)
    exit_end_s |=> state_q == SXE_IDLE && !busy_o)
    else $error("exit did not close at second cycle end");
endmodule
`default_nettype wire

// >>> common/sxe_pkg.sv
// Constants and types for the subroutine-exit execution block
package sxe_pkg;
  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int OPC_W = 16;
  // ----------------------------------------
  // Opcode layout
  // ----------------------------------------
  localparam logic [OPC_W-1:0] OPC_EXIT_MATCH = 16'h0012;
  localparam logic [OPC_W-1:0] OPC_EXIT_MASK = 16'hFFFE;
  localparam int OPC_RESTORE_BIT = 0;
  // ----------------------------------------
  // Phases of an instruction cycle
  // ----------------------------------------
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q4 = 2'h3;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  typedef enum logic [1:0] {SXE_IDLE, SXE_POP, SXE_NOP} sxe_state_t;
endpackage

// >>> design/sxe_phase_gen.sv
// Four-phase sequencer that splits each instruction cycle
`timescale 1ns/1ps
`default_nettype none
module sxe_phase_gen
  import sxe_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Phase outputs
  output logic [1:0] phase_o
);
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      phase_o <= PHASE_Q1;
    else
      phase_o <= phase_o + 2'h1;
  end
endmodule
`default_nettype wire

// >>> verif/subroutine_exit_execution_bench.sv
// Self-checking bench for the subroutine-exit execution block
`timescale 1ns/1ps
`default_nettype none
module subroutine_exit_execution_bench;
  import sxe_pkg::*;
`define CHK(n, e, g) \
  begin checks++; if ((g) !== (e)) \
  begin errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
  logic clk_i, reset_i, opcode_valid_i, stack_pop_o, busy_o;
  logic wreg_load_i, flags_load_i, bank_load_i, latch_load_i;
  logic [OPC_W-1:0] opcode_i;
  logic [PC_W-1:0] stack_top_i, pc_o;
  logic [DATA_W-1:0] accumulator_shadow_i, flags_shadow_i, bank_select_shadow_i;
  logic [DATA_W-1:0] wreg_data_i, flags_data_i, bank_data_i;
  logic [DATA_W-1:0] latch_upper_data_i, latch_high_data_i;
  logic [DATA_W-1:0] wreg_o, flags_o, bank_select_reg_o, pc_latch_upper_o, pc_latch_high_o;
  logic [1:0] ph;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  sxe_exec u_dut (.clk_i, .reset_i, .opcode_i, .opcode_valid_i, .stack_top_i, .stack_pop_o,
    .accumulator_shadow_i, .flags_shadow_i, .bank_select_shadow_i, .wreg_load_i,
    .wreg_data_i, .flags_load_i, .flags_data_i, .bank_load_i, .bank_data_i, .latch_load_i,
    .latch_upper_data_i, .latch_high_data_i, .pc_o, .wreg_o, .flags_o, .bank_select_reg_o,
    .pc_latch_upper_o, .pc_latch_high_o, .busy_o);
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Phase the next rising edge will see, tracked from reset release
  always @(posedge clk_i) ph <= reset_i ? 2'h0 : ph + 2'h1;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 500)
    begin
      errors++;
      close_out();
    end
  end
  task automatic set_loads(input logic en);
    wreg_load_i = en;
    flags_load_i = en;
    bank_load_i = en;
    latch_load_i = en;
  endtask
  // ----------------------------------------
  // One exit, loads offered while busy
  // ----------------------------------------
  task automatic do_exit(input logic [OPC_W-1:0] op, input logic [PC_W-1:0] top,
    input logic [DATA_W-1:0] ew, input logic [DATA_W-1:0] ef, input logic [DATA_W-1:0] eb);
    @(negedge clk_i);
    while (ph !== 2'h0) @(negedge clk_i);
    opcode_i = op;
    opcode_valid_i = 1'b1;
    stack_top_i = top;
    @(negedge clk_i);
    set_loads(1'b1);
    @(negedge clk_i);
    `CHK("busy", 1'b1, busy_o)
    repeat (2) @(negedge clk_i);
    `CHK("pop", 1'b1, stack_pop_o)
    `CHK("pc", top, pc_o)
    `CHK("wreg", ew, wreg_o)
    `CHK("flags", ef, flags_o)
    `CHK("bank", eb, bank_select_reg_o)
    `CHK("latch_u", 8'h44, pc_latch_upper_o)
    `CHK("latch_h", 8'h55, pc_latch_high_o)
    // Popped value no longer held by the stack
    stack_top_i = ~top;
    // Exit still offered at the second cycle's first phase must be ignored
    @(negedge clk_i);
    opcode_valid_i = 1'b0;
    set_loads(1'b0);
    `CHK("pop_end", 1'b0, stack_pop_o)
    repeat (3) @(negedge clk_i);
    `CHK("busy_end", 1'b0, busy_o)
  endtask
  task automatic test_keep();
    set_loads(1'b1);
    @(negedge clk_i);
    set_loads(1'b0);
    `CHK("wreg_ld", 8'h11, wreg_o)
    `CHK("latch_ld", 8'h44, pc_latch_upper_o)
    wreg_data_i = 8'h66;
    latch_upper_data_i = 8'h77;
    do_exit(16'h0012, 21'h1ABCDE, 8'h11, 8'h22, 8'h33);
    $display("test_keep done");
  endtask
  task automatic test_restore();
    do_exit(16'h0013, 21'h0F0F0F, 8'hA1, 8'hB2, 8'hC3);
    $display("test_restore done");
  endtask
  task automatic test_refuse();
    logic [OPC_W-1:0] ops [8] = '{16'h0013, 16'h0013, 16'h0013, 16'h0014,
      16'h0010, 16'h0032, 16'h0112, 16'h1012};
    while (ph !== 2'h1) @(negedge clk_i);
    opcode_valid_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      opcode_i = ops[i];
      // Restore-form exits sit off the first phase; each other word spans a first phase
      repeat ((i < 3) ? 1 : 4)
      begin
        @(negedge clk_i);
        `CHK("idle", 1'b0, busy_o)
        `CHK("no_pop", 1'b0, stack_pop_o)
      end
    end
    opcode_valid_i = 1'b0;
    `CHK("pc_kept", 21'h0F0F0F, pc_o)
    $display("test_refuse done");
  endtask
  // ----------------------------------------
  // Reset in mid-exit, then a clean exit
  // ----------------------------------------
  task automatic test_reset();
    while (ph !== 2'h0) @(negedge clk_i);
    opcode_i = 16'h0013;
    opcode_valid_i = 1'b1;
    stack_top_i = 21'h054321;
    repeat (2) @(negedge clk_i);
    opcode_valid_i = 1'b0;
    reset_i = 1'b1;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    `CHK("rst_pop", 1'b0, stack_pop_o)
    `CHK("rst_pc", 21'h000000, pc_o)
    `CHK("rst_wreg", 8'h00, wreg_o)
    `CHK("rst_busy", 1'b0, busy_o)
    wreg_data_i = 8'h11;
    latch_upper_data_i = 8'h44;
    set_loads(1'b1);
    @(negedge clk_i);
    set_loads(1'b0);
    do_exit(16'h0012, 21'h1ABCDE, 8'h11, 8'h22, 8'h33);
    $display("test_reset done");
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    reset_i = 1'b1;
    opcode_i = 16'h0000;
    opcode_valid_i = 1'b0;
    stack_top_i = 21'h000000;
    accumulator_shadow_i = 8'hA1;
    flags_shadow_i = 8'hB2;
    bank_select_shadow_i = 8'hC3;
    set_loads(1'b0);
    wreg_data_i = 8'h11;
    flags_data_i = 8'h22;
    bank_data_i = 8'h33;
    latch_upper_data_i = 8'h44;
    latch_high_data_i = 8'h55;
    repeat (4) @(negedge clk_i);
    reset_i = 1'b0;
    test_keep();
    test_restore();
    test_refuse();
    test_reset();
    close_out();
  end
endmodule
`default_nettype wire
